// File: pkg/pic_defines.svh
// constants for the pulse input counter bank
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

`define PIC_NUM_CH 16
`define PIC_GRP_PTS 8
`define PIC_CNT_W 12
`define PIC_IDX_W 4
`define PIC_CNT_MAX 12'hfff
`define PIC_CNT_ONE 12'h001
`define PIC_CNT_ZERO 12'h000

// timing
`define PIC_CLK_PERIOD_NS 4
// single pole near 200 Hz: tau = 1/(2*pi*200 Hz), about 800 us
`define PIC_FILT_TAU_NS 800000
`define PIC_FILT_STEPS 16
`define PIC_FILT_TICK_NS (`PIC_FILT_TAU_NS / `PIC_FILT_STEPS)
`define PIC_FILT_TICK_CYC (`PIC_FILT_TICK_NS / `PIC_CLK_PERIOD_NS)
`define PIC_DIV_W 16
`define PIC_DIV_ONE 16'h0001
`define PIC_DIV_ZERO 16'h0000

// filter integrator
`define PIC_ACC_W 4
`define PIC_ACC_MAX 4'hf
`define PIC_ACC_MIN 4'h0
`define PIC_ACC_STEP 4'h1

`endif

// File: pkg/pic_pkg.sv
// types for the pulse input counter bank
package pic_pkg;

    typedef enum logic [1:0] {
        PIC_VAR_LOW_DC = 2'b00,
        PIC_VAR_HIGH_DC = 2'b01,
        PIC_VAR_HIGH_AC = 2'b10
    } pic_variant_e;

    typedef struct packed {
        logic [3:0] acc;
        logic lvl;
    } pic_filt_s;

    typedef struct packed {
        logic [15:0] s1;
        logic [15:0] s2;
        logic [15:0] prev;
        logic [15:0][11:0] cnt;
        logic [15:0] ovf;
        logic [15:0] div;
        logic tick;
        logic [15:0] led;
        logic rd_valid;
        logic [11:0] rd_count;
        logic rd_ovf;
    } pic_bank_s;

    typedef struct packed {
        logic valid;
        logic [11:0] count;
        logic ovf;
    } pic_rd_s;

endpackage

// File: hw/pic_filt.sv
// per-point bounce filter: integrator with hysteresis, approximating a single pole
`timescale 1ns/1ps
`include "pic_defines.svh"

module pic_filt
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic low_speed,
    input wire logic in_lvl,
    output logic state
);

    pic_pkg::pic_filt_s r_q;
    pic_pkg::pic_filt_s r_d;

    always_comb
    begin
        r_d = r_q;
        if (tick)
        begin
            if (in_lvl && (r_q.acc != `PIC_ACC_MAX))
            begin
                r_d.acc = r_q.acc + `PIC_ACC_STEP;
            end
            else if (!in_lvl && (r_q.acc != `PIC_ACC_MIN))
            begin
                r_d.acc = r_q.acc - `PIC_ACC_STEP;
            end
        end
        // hysteresis: a bounce must outlast the full travel to flip the state
        if (r_d.acc == `PIC_ACC_MAX)
        begin
            r_d.lvl = 1'b1;
        end
        else if (r_d.acc == `PIC_ACC_MIN)
        begin
            r_d.lvl = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // fast variants bypass the filter so a 10 kHz pulse train is not swallowed
    assign state = low_speed ? r_q.lvl : in_lvl;

endmodule // pic_filt

// File: hw/pic_bank.sv
// sixteen-point pulse counter bank with read-and-clear counters
`timescale 1ns/1ps
`include "pic_defines.svh"

module pic_bank
#(
    parameter int FILT_TICK_CYC = `PIC_FILT_TICK_CYC
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire pic_pkg::pic_variant_e variant,
    input wire logic [`PIC_NUM_CH-1:0] pt_on,
    input wire logic rd_req,
    input wire logic [`PIC_IDX_W-1:0] rd_idx,
    output pic_pkg::pic_rd_s rd_rsp,
    output logic [`PIC_NUM_CH-1:0] led
);

    localparam logic [`PIC_DIV_W-1:0] DIV_LAST = FILT_TICK_CYC[`PIC_DIV_W-1:0] - `PIC_DIV_ONE;

    pic_pkg::pic_bank_s r_q;
    pic_pkg::pic_bank_s r_d;
    logic [`PIC_NUM_CH-1:0] st;
    logic low_speed;

    // only the low-speed variant suppresses bounce; fast DC relies on clean sources
    assign low_speed = (variant == pic_pkg::PIC_VAR_LOW_DC);

    // per-point filter; the group split is electrical only, logic is uniform
    genvar gi;
    generate
        for (gi = 0; gi < `PIC_NUM_CH; gi++)
        begin : g_pt
            pic_filt u_filt
            (
                .mclk(mclk),
                .rst(rst),
                .tick(r_q.tick),
                .low_speed(low_speed),
                .in_lvl(r_q.s2[gi]),
                .state(st[gi])
            );
        end
    endgenerate

    always_comb
    begin
        r_d = r_q;
        // two-flop synchroniser; s1 feeds only s2
        r_d.s1 = pt_on;
        r_d.s2 = r_q.s1;
        r_d.prev = st;
        r_d.led = st;

        // filter sample tick divider
        if (r_q.div >= DIV_LAST)
        begin
            r_d.div = `PIC_DIV_ZERO;
            r_d.tick = 1'b1;
        end
        else
        begin
            r_d.div = r_q.div + `PIC_DIV_ONE;
            r_d.tick = 1'b0;
        end

        r_d.rd_valid = rd_req;
        if (rd_req)
        begin
            r_d.rd_count = r_q.cnt[rd_idx];
            r_d.ovf = r_q.ovf;
            r_d.rd_ovf = r_q.ovf[rd_idx];
        end

        for (int i = 0; i < `PIC_NUM_CH; i++)
        begin
            if (rd_req && (rd_idx == i[`PIC_IDX_W-1:0]))
            begin
                // an edge in the read cycle starts the new count, never lost
                r_d.cnt[i] = (st[i] && !r_q.prev[i]) ? `PIC_CNT_ONE : `PIC_CNT_ZERO;
                r_d.ovf[i] = 1'b0;
            end
            else if (st[i] && !r_q.prev[i])
            begin
                // wraps after 4096 pulses; flag stays until the host reads
                r_d.cnt[i] = r_q.cnt[i] + `PIC_CNT_ONE;
                if (r_q.cnt[i] == `PIC_CNT_MAX)
                begin
                    r_d.ovf[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign rd_rsp.valid = r_q.rd_valid;
    assign rd_rsp.count = r_q.rd_count;
    assign rd_rsp.ovf = r_q.rd_ovf;
    assign led = r_q.led;

endmodule // pic_bank

// File: verif/pic_bank_checker.sv
// port assertions for the counter bank
`timescale 1ns/1ps
module pic_bank_checker
(
    input wire logic mclk,
    input wire logic rst,
    input wire pic_pkg::pic_variant_e variant,
    input wire logic [15:0] pt_on,
    input wire logic rd_req,
    input wire logic [3:0] rd_idx,
    input wire pic_pkg::pic_rd_s rd_rsp,
    input wire logic [15:0] led
);
    wire fast = variant != pic_pkg::PIC_VAR_LOW_DC;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // inputs quiet for five cycles, so no edge can land between the two reads
    sequence s_dbl;
        (fast && $stable(pt_on)) [*5] ##0 rd_req ##1 (rd_req && $stable(rd_idx));
    endsequence
    property p_ans; rd_req |=> rd_rsp.valid; endproperty
    a_ans: assert property (p_ans) else $error("read unanswered");
    property p_idle; !rd_req |=> !rd_rsp.valid; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_cnt; !rd_req |=> $stable(rd_rsp.count); endproperty
    a_cnt: assert property (p_cnt) else $error("count moved");
    property p_ovf; !rd_req |=> $stable(rd_rsp.ovf); endproperty
    a_ovf: assert property (p_ovf) else $error("flag moved");
    property p_led;
        fast && !$past(rst) && !$past(rst, 2) && !$past(rst, 3) |-> led == $past(pt_on, 3);
    endproperty
    a_led: assert property (p_led) else $error("indicator wrong");
    property p_flt; !fast && led != $past(led) |=> $stable(led) [*2]; endproperty
    a_flt: assert property (p_flt) else $error("filter too fast");
    property p_clr; s_dbl |=> rd_rsp.count == 12'h000; endproperty
    a_clr: assert property (p_clr) else $error("count not cleared");
    property p_clro; s_dbl |=> !rd_rsp.ovf; endproperty
    a_clro: assert property (p_clro) else $error("flag not cleared");
endmodule // pic_bank_checker
bind pic_bank pic_bank_checker chk (.mclk(mclk), .rst(rst), .variant(variant),
    .pt_on(pt_on), .rd_req(rd_req), .rd_idx(rd_idx), .rd_rsp(rd_rsp), .led(led));

// File: verif/pic_host.sv
// host model issuing counter reads
`timescale 1ns/1ps
module pic_host
(
    input wire logic mclk,
    input wire logic go,
    input wire logic [3:0] idx,
    output logic rd_req = 1'b0,
    output logic [3:0] rd_idx = 4'h0
);
    // idle index flips each cycle so a stale one never passes for valid
    always @(negedge mclk)
    begin
        rd_req <= go;
        rd_idx <= go ? idx : ~rd_idx;
    end
endmodule // pic_host

// File: verif/pic_bank_tb_top.sv
// bench: pulse counting model against the counter bank
`timescale 1ns/1ps
module pic_bank_tb_top;
    logic mclk = 1'b0, rst = 1'b1, go = 1'b0, rd_req;
    logic [3:0] idx = 4'h0, rd_idx;
    logic [15:0] pt_on = 16'h0000, led;
    pic_pkg::pic_variant_e variant = pic_pkg::PIC_VAR_LOW_DC;
    pic_pkg::pic_rd_s rd_rsp;
    int failures = 0, cmp_count = 0, v, cnt[16];
    initial forever #2 mclk = ~mclk;
    pic_host host (.mclk(mclk), .go(go), .idx(idx), .rd_req(rd_req), .rd_idx(rd_idx));
    pic_bank #(.FILT_TICK_CYC(4)) dut (.mclk(mclk), .rst(rst), .variant(variant),
        .pt_on(pt_on), .rd_req(rd_req), .rd_idx(rd_idx), .rd_rsp(rd_rsp), .led(led));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %0t %h %h", $time, g, e);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // long pulses get a one-cycle dip, which the filter must swallow
    task automatic pulse(input logic [15:0] m, input int h);
        @(negedge mclk) pt_on = m;
        repeat (h) @(negedge mclk);
        pt_on = h > 9 ? 16'h0000 : m;
        @(negedge mclk) pt_on = m;
        repeat (h) @(negedge mclk);
        chk(led, m);
        pt_on = 16'h0000;
        repeat (2 * h) @(negedge mclk);
        for (int i = 0; i < 16; i++)
            cnt[i] += m[i];
    endtask
    // n reads back to back; the answer of the last one is checked
    task automatic rd(input int c, input int n);
        @(posedge mclk) go <= 1'b1;
        idx <= 4'(c);
        repeat (n) @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        chk({2'h0, rd_rsp}, {3'h1, 12'(cnt[c]), cnt[c] > 4095});
        cnt[c] = 0;
    endtask
    initial
    begin
        void'($urandom(32'h5bd6));
        for (v = 0; v < 3; v++)
        begin
            rst = 1'b1;
            variant = pic_pkg::pic_variant_e'(v);
            cnt = '{default: 0};
            repeat (8) @(negedge mclk);
            rst = 1'b0;
            repeat (6) pulse(16'($urandom()), v > 0 ? 4 : 70);
            for (int k = 0; k < 16; k++)
                rd(k, 1);
        end
        repeat (4097) pulse(16'h0008, 4);
        rd(3, 1);
        pulse(16'h0020, 4);
        cnt[5] = 0;
        rd(5, 2);
        print_verdict();
    end
endmodule // pic_bank_tb_top
